//--- hw/t1_alarm_pkg.sv
/*
  Shared constants for the T1 receive alarm and status block: register offsets, bit positions,
  reset values, detector thresholds and time counts, and the carrier state encoding.
  Assumes a 250 MHz system clock.
*/
package t1_alarm_pkg;
  localparam logic [7:0] LEVEL_STATUS_ADDR = 8'h10;
  localparam logic [7:0] ALARM_STATUS_ADDR = 8'h20;
  localparam logic [7:0] EVENT_FLAGS_ADDR = 8'h31;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  localparam int SYNC_REGAINED_BIT = 7;
  localparam int CARRIER_RESTORED_BIT = 6;
  localparam int TX_STORE_FULL_BIT = 5;
  localparam int TX_STORE_EMPTY_BIT = 4;
  localparam int TX_SLIP_BIT = 3;
  localparam int BLUE_CLEARED_BIT = 2;
  localparam int RX_DENSITY_BIT = 1;
  localparam int TX_DENSITY_BIT = 0;

  localparam int LEVEL_CODE_LO_BIT = 6;
  localparam int JITTER_LIMIT_BIT = 5;
  localparam int RX_CLOCK_LOSS_BIT = 4;
  localparam int FRAMER_CARRIER_LOSS_BIT = 3;

  localparam int BLUE_ALARM_BIT = 3;
  localparam int YELLOW_ALARM_BIT = 2;
  localparam int LINE_CARRIER_LOSS_BIT = 1;
  localparam int RX_SYNC_LOSS_BIT = 0;

  localparam int CLK_PERIOD_NS = 4;
  localparam int CLOCK_LOSS_NS = 3000;
  localparam int CLOCK_LOSS_CYC = (CLOCK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLUE_WINDOW_MS = 3;
  localparam int BLUE_WINDOW_CYC = (BLUE_WINDOW_MS * 1000000) / CLK_PERIOD_NS;
  localparam int BLUE_MAX_ZEROS = 5;

  localparam int RED_ZERO_RUN = 192;
  localparam int RED_CLEAR_WINDOW = 112;
  localparam int RED_CLEAR_ONES = 14;
  localparam int DENSITY_MAX_ZEROS = 15;
  localparam int JA_DEPTH_DEFAULT = 128;
  localparam int JA_MARGIN = 4;

  localparam int YEL_BIT2_WINDOW = 256;
  localparam int YEL_BIT2_ZEROS = 254;
  localparam int YEL_FDL_RUN = 16;
  localparam int YEL_FDL_WINDOW = 16;
  localparam int YEL_FDL_CLEAR_MAX = 14;

  typedef enum logic [2:0] {
    CARRIER_OK = 3'b001,
    CARRIER_LOST = 3'b010,
    CARRIER_TRIAL = 3'b100
  } carrier_state_t;
endpackage

//--- hw/rx_stream_if.sv
/*
  Recovered receive bit stream passed from the top to the line alarm detector.
  Assumes the source drives one bit strobe per receive clock rising edge.
*/
`timescale 1ns/100ps
interface rx_stream_if;
  logic ce;
  logic bit_stb;
  logic mark;
  modport source (output ce, output bit_stb, output mark);
  modport sink (input ce, input bit_stb, input mark);
endinterface

//--- hw/line_alarm_detect.sv
/*
  Red alarm, blue alarm and receive pulse density detection on the receive bit stream.
  Assumes one strobe per received bit; a mark is a pulse on either rail.
*/
`timescale 1ns/100ps
module line_alarm_detect
  import t1_alarm_pkg::*;
#(
  parameter int BLUE_CYC = BLUE_WINDOW_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  rx_stream_if.sink rx,
  output logic red_out,
  output logic blue_out,
  output logic density_viol_out
);
  localparam int BT_W = $clog2(BLUE_CYC + 1);
  carrier_state_t cst_r, cst_nxt;
  logic [7:0] zrun_r;
  logic [6:0] win_r, win_nxt;
  logic [3:0] ones_r, ones_nxt;
  logic [BT_W-1:0] bt_r;
  logic [2:0] bz_r;
  logic blue_r;
  logic dv_r;

  wire zero_bit = rx.bit_stb & ~rx.mark;
  wire one_bit = rx.bit_stb & rx.mark;
  wire zero_hit = zero_bit & (zrun_r == 8'(RED_ZERO_RUN - 1));
  wire [7:0] zrun_nxt = one_bit ? 8'h00 : (zero_bit && zrun_r != 8'hff) ? zrun_r + 8'h01 : zrun_r;
  wire bt_end = (bt_r == BT_W'(BLUE_CYC - 1));
  wire bz_sat = (bz_r == 3'(BLUE_MAX_ZEROS + 1));
  wire [2:0] bz_inc = (zero_bit && !bz_sat) ? bz_r + 3'h1 : bz_r;

  always_comb begin
    cst_nxt = cst_r;
    win_nxt = win_r;
    ones_nxt = ones_r;
    unique case (cst_r)
      CARRIER_OK: begin
        if (zero_hit) cst_nxt = CARRIER_LOST; // R11 R17
      end
      CARRIER_LOST: begin
        if (one_bit) begin
          cst_nxt = CARRIER_TRIAL;
          win_nxt = 7'h01;
          ones_nxt = 4'h1;
        end
      end
      CARRIER_TRIAL: begin
        if (rx.bit_stb) begin
          win_nxt = win_r + 7'h01;
          if (one_bit) ones_nxt = ones_r + 4'h1;
          if (one_bit && ones_r == 4'(RED_CLEAR_ONES - 1)) begin
            cst_nxt = CARRIER_OK; // R17 R11
          end else if (win_r == 7'(RED_CLEAR_WINDOW - 1)) begin
            cst_nxt = CARRIER_LOST;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cst_r <= CARRIER_LOST;
      zrun_r <= 8'h00;
      win_r <= 7'h00;
      ones_r <= 4'h0;
    end else if (rx.ce) begin
      cst_r <= cst_nxt;
      zrun_r <= zrun_nxt;
      win_r <= win_nxt;
      ones_r <= ones_nxt;
    end
  end

  // A framed all-ones signal carries several framing zeros per window, so it never trips.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bt_r <= '0;
      bz_r <= 3'h0;
      blue_r <= 1'b0;
      dv_r <= 1'b0;
    end else if (rx.ce) begin
      bt_r <= bt_end ? '0 : bt_r + BT_W'(1);
      bz_r <= bt_end ? 3'h0 : bz_inc;
      if (bt_end) blue_r <= (bz_inc <= 3'(BLUE_MAX_ZEROS)); // R13 R18
      dv_r <= zero_bit & (zrun_r == 8'(DENSITY_MAX_ZEROS)); // R6
    end
  end

  assign red_out = (cst_r != CARRIER_OK);
  assign blue_out = blue_r;
  assign density_viol_out = dv_r;
endmodule

//--- hw/yellow_detect.sv
/*
  Yellow alarm detection in the D4 bit-2, D4 twelfth-F-bit and ESF data link modes.
  Assumes the framer supplies one strobe per sample with its value.
*/
`timescale 1ns/100ps
module yellow_detect
  import t1_alarm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic mode_select,
  input wire logic esf_mode,
  input wire logic bit2_stb,
  input wire logic bit2_val,
  input wire logic fbit_stb,
  input wire logic fbit_val,
  input wire logic fdl_stb,
  input wire logic fdl_match,
  output logic yellow_out
);
  logic [7:0] b2_pos_r;
  logic [8:0] b2_zero_r;
  logic y_b2_r, f_last_r, y_f_r, y_e_r;
  logic [4:0] run_r, hits_r;
  logic [3:0] fwin_r;

  wire [8:0] b2_zero_nxt = b2_zero_r + {8'h00, ~bit2_val};
  wire b2_end = (b2_pos_r == 8'(YEL_BIT2_WINDOW - 1));
  wire [4:0] run_nxt = !fdl_match ? 5'h00 : (run_r == 5'(YEL_FDL_RUN)) ? run_r : run_r + 5'h01;
  wire [4:0] hits_nxt = hits_r + 5'(fdl_match);
  wire fwin_end = (fwin_r == 4'(YEL_FDL_WINDOW - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      b2_pos_r <= 8'h00;
      b2_zero_r <= 9'h000;
      y_b2_r <= 1'b0;
    end else if (ce && bit2_stb) begin
      b2_pos_r <= b2_pos_r + 8'h01;
      b2_zero_r <= b2_end ? 9'h000 : b2_zero_nxt;
      if (b2_end) y_b2_r <= (b2_zero_nxt >= 9'(YEL_BIT2_ZEROS)); // R14
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f_last_r <= 1'b0;
      y_f_r <= 1'b0;
    end else if (ce && fbit_stb) begin
      f_last_r <= fbit_val;
      if (fbit_val && f_last_r) y_f_r <= 1'b1; // R15
      else if (!fbit_val && !f_last_r) y_f_r <= 1'b0; // R15
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 5'h00;
      hits_r <= 5'h00;
      fwin_r <= 4'h0;
      y_e_r <= 1'b0;
    end else if (ce && fdl_stb) begin
      run_r <= run_nxt;
      fwin_r <= fwin_r + 4'h1;
      hits_r <= fwin_end ? 5'h00 : hits_nxt;
      if (run_nxt == 5'(YEL_FDL_RUN)) y_e_r <= 1'b1; // R16
      else if (fwin_end && hits_nxt <= 5'(YEL_FDL_CLEAR_MAX)) y_e_r <= 1'b0; // R16
    end
  end

  assign yellow_out = esf_mode ? y_e_r : (mode_select ? y_f_r : y_b2_r);
endmodule

//--- hw/t1_receive_alarm_status.sv
/*
  Receive alarm and status logic of a T1 transceiver with its three latched status registers
  on the byte-wide parallel port and the alarm-change interrupt pin.
  Assumes every input is synchronous to REF_CLK_IN and the receive clock is far slower.
*/
// How it works
// R1: Sync regained sets event bit 7, held.
// R2: Carrier restored sets event bit 6, held.
// R3: Transmit store overflow/underrun set bits 5, 4.
// R4: Any transmit store slip sets bit 3.
// R5: Blue alarm ending sets bit 2, held.
// R6: Sixteen receive zeros set density bit 1.
// R7: Sixteen transmit zeros set density bit 0.
// R8: Level code shown in level bits 7:6.
// R9: Jitter FIFO within four of limit flags.
// R10: Three microseconds without receive clock edge flags.
// R11: Framer carrier loss: 192 zeros, 14/112 clears.
// R12: Level register bits 2:0 read zero.
// R13: Blue: at most five zeros per 3ms.
// R14: Bit-2 yellow: 254 of 256 zeros.
// R15: F-bit yellow: two equal consecutive values.
// R16: ESF yellow: 16 patterns set, 14/16 clear.
// R17: Red alarm: 192 zeros set, 14/112 clear.
// R18: Blue detector tolerates errors, ignores framed ones.
// R19: Software qualifies blue with sync loss.
// R20: Flags latch until read; alarms stay.
// R21: Software writes mask, reads, writes back.
// R22: Alarm change pulls interrupt low until read.
`timescale 1ns/100ps
module t1_receive_alarm_status
  import t1_alarm_pkg::*;
#(
  parameter int BLUE_CYC = BLUE_WINDOW_CYC,
  parameter int JA_DEPTH = JA_DEPTH_DEFAULT,
  parameter int JA_W = 8
) (
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic CE_IN,
  input wire logic RX_CLOCK_INPUT_IN,
  input wire logic RX_POSITIVE_RAIL_IN,
  input wire logic RX_NEGATIVE_RAIL_IN,
  input wire logic SYNC_ACQUIRED_IN,
  input wire logic TX_STORE_FULL_IN,
  input wire logic TX_STORE_EMPTY_IN,
  input wire logic TX_BIT_STB_IN,
  input wire logic TX_MARK_IN,
  input wire logic [1:0] LEVEL_CODE_IN,
  input wire logic [JA_W-1:0] JA_FILL_IN,
  input wire logic YELLOW_MODE_SELECT_IN,
  input wire logic ESF_MODE_IN,
  input wire logic CHAN_BIT2_STB_IN,
  input wire logic CHAN_BIT2_IN,
  input wire logic FBIT12_STB_IN,
  input wire logic FBIT12_IN,
  input wire logic FDL_PATTERN_STB_IN,
  input wire logic FDL_PATTERN_MATCH_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] WDATA_IN,
  output logic [7:0] RDATA_OUT,
  output logic INT_N_OUT
);
  localparam int CL_W = $clog2(CLOCK_LOSS_CYC + 1);
  localparam logic [7:0] REG_ADDR [3] = '{LEVEL_STATUS_ADDR, ALARM_STATUS_ADDR, EVENT_FLAGS_ADDR};

  rx_stream_if rxs ();
  logic rclk_d_r, stb_r, mark_r, sync_d_r, red_d_r, blue_d_r;
  logic [1:0] level_r;
  logic [CL_W-1:0] cl_cnt_r;
  logic [3:0] tz_r;
  logic [3:0] alarm_d_r, pend_r, amask_r;
  logic [7:0] lat_r [3];
  logic [7:0] snap_r [3];
  logic [2:0] armed_r;
  logic [7:0] set_v [3];
  logic [7:0] pres_v [3];
  logic [7:0] clr_v [3];
  logic [2:0] sel;
  logic red, blue, yellow, rx_dv;
  logic [7:0] ev_set, lvl_set;

  assign rxs.ce = CE_IN;
  assign rxs.bit_stb = stb_r;
  assign rxs.mark = mark_r;

  line_alarm_detect #(.BLUE_CYC(BLUE_CYC)) u_line (
    .clk(REF_CLK_IN),
    .rst_n(RSTN_IN),
    .rx(rxs),
    .red_out(red),
    .blue_out(blue),
    .density_viol_out(rx_dv)
  );

  yellow_detect u_yellow (
    .clk(REF_CLK_IN),
    .rst_n(RSTN_IN),
    .ce(CE_IN),
    .mode_select(YELLOW_MODE_SELECT_IN),
    .esf_mode(ESF_MODE_IN),
    .bit2_stb(CHAN_BIT2_STB_IN),
    .bit2_val(CHAN_BIT2_IN),
    .fbit_stb(FBIT12_STB_IN),
    .fbit_val(FBIT12_IN),
    .fdl_stb(FDL_PATTERN_STB_IN),
    .fdl_match(FDL_PATTERN_MATCH_IN),
    .yellow_out(yellow)
  );

  wire rclk_edge = RX_CLOCK_INPUT_IN ^ rclk_d_r;
  wire clk_lost = (cl_cnt_r == CL_W'(CLOCK_LOSS_CYC));
  wire [CL_W-1:0] cl_nxt = rclk_edge ? '0 : (clk_lost ? cl_cnt_r : cl_cnt_r + CL_W'(1));
  wire ja_near = (JA_FILL_IN >= JA_W'(JA_DEPTH - JA_MARGIN)) || (JA_FILL_IN <= JA_W'(JA_MARGIN));
  wire tx_zero = TX_BIT_STB_IN & ~TX_MARK_IN;
  wire tx_dv = tx_zero & (tz_r == 4'(DENSITY_MAX_ZEROS));
  wire tx_one = TX_BIT_STB_IN & TX_MARK_IN;
  wire [3:0] tz_nxt = tx_one ? 4'h0 : (tx_zero && !tx_dv) ? tz_r + 4'h1 : tz_r;
  wire [3:0] alarm_now = {blue, yellow, red, ~SYNC_ACQUIRED_IN};
  wire [3:0] int_rel = (RD_IN && sel[1]) ? amask_r : 4'h0;
  wire [3:0] pend_nxt = (alarm_now ^ alarm_d_r) | (pend_r & ~int_rel);

  always_comb begin
    ev_set = STATUS_RESET;
    ev_set[SYNC_REGAINED_BIT] = SYNC_ACQUIRED_IN & ~sync_d_r; // R1
    ev_set[CARRIER_RESTORED_BIT] = red_d_r & ~red; // R2
    ev_set[TX_STORE_FULL_BIT] = TX_STORE_FULL_IN; // R3
    ev_set[TX_STORE_EMPTY_BIT] = TX_STORE_EMPTY_IN; // R3
    ev_set[TX_SLIP_BIT] = TX_STORE_FULL_IN | TX_STORE_EMPTY_IN; // R4
    ev_set[BLUE_CLEARED_BIT] = blue_d_r & ~blue; // R5
    ev_set[RX_DENSITY_BIT] = rx_dv; // R6
    ev_set[TX_DENSITY_BIT] = tx_dv; // R7
    lvl_set = STATUS_RESET;
    lvl_set[JITTER_LIMIT_BIT] = ja_near; // R9
    lvl_set[RX_CLOCK_LOSS_BIT] = clk_lost; // R10
    lvl_set[FRAMER_CARRIER_LOSS_BIT] = red; // R11
  end

  assign set_v[0] = lvl_set;
  assign set_v[1] = STATUS_RESET;
  assign set_v[2] = ev_set;
  assign pres_v[0] = STATUS_RESET;
  assign pres_v[1] = {4'h0, alarm_now}; // R20
  assign pres_v[2] = STATUS_RESET;

  // The write that follows a read clears only the bits it names, so an event landing
  // between the read and the write-back is kept; a set in the clearing cycle also wins.
  for (genvar r = 0; r < 3; r++) begin : g_reg
    assign sel[r] = (ADDR_IN == REG_ADDR[r]);
    assign clr_v[r] = (WR_IN && sel[r] && armed_r[r]) ? WDATA_IN : 8'h00; // R21
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
        lat_r[r] <= STATUS_RESET;
        snap_r[r] <= STATUS_RESET;
        armed_r[r] <= 1'b0;
      end else if (CE_IN) begin
        lat_r[r] <= set_v[r] | pres_v[r] | (lat_r[r] & ~clr_v[r]); // R20
        if (WR_IN && sel[r]) begin
          armed_r[r] <= ~armed_r[r];
          if (!armed_r[r]) snap_r[r] <= (snap_r[r] & ~WDATA_IN) | (lat_r[r] & WDATA_IN); // R21
        end
      end
    end
  end

  wire [2:0] lvl_flags = snap_r[0][JITTER_LIMIT_BIT:FRAMER_CARRIER_LOSS_BIT];
  wire [7:0] lvl_read = {level_r, lvl_flags, 3'h0}; // R8 R12
  wire [7:0] rd_mux = sel[0] ? lvl_read : sel[1] ? snap_r[1] : sel[2] ? snap_r[2] : UNMAPPED_READ;

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rclk_d_r <= 1'b0;
      stb_r <= 1'b0;
      mark_r <= 1'b0;
      cl_cnt_r <= '0;
      tz_r <= 4'h0;
      level_r <= 2'h0;
    end else if (CE_IN) begin
      rclk_d_r <= RX_CLOCK_INPUT_IN;
      stb_r <= RX_CLOCK_INPUT_IN & ~rclk_d_r;
      mark_r <= RX_POSITIVE_RAIL_IN | RX_NEGATIVE_RAIL_IN;
      cl_cnt_r <= cl_nxt; // R10
      tz_r <= tz_nxt; // R7
      level_r <= LEVEL_CODE_IN; // R8
    end
  end

  // Alarm history starts at the reset values, so a framer out of sync at reset raises one
  // interrupt that software acknowledges with its first poll.
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      sync_d_r <= 1'b0;
      red_d_r <= 1'b0;
      blue_d_r <= 1'b0;
      alarm_d_r <= 4'h0;
      pend_r <= 4'h0;
      amask_r <= 4'h0;
      RDATA_OUT <= UNMAPPED_READ;
      INT_N_OUT <= 1'b1;
    end else if (CE_IN) begin
      sync_d_r <= SYNC_ACQUIRED_IN;
      red_d_r <= red;
      blue_d_r <= blue;
      alarm_d_r <= alarm_now;
      pend_r <= pend_nxt; // R22
      INT_N_OUT <= ~|pend_nxt; // R22
      if (WR_IN && sel[1] && !armed_r[1]) amask_r <= WDATA_IN[3:0];
      if (RD_IN) RDATA_OUT <= rd_mux;
    end
  end
endmodule

//--- verif/t1_alarm_checker_props.sv
/*
  Concurrent checks on the ports of the T1 receive alarm block, bound into its top module.
  Assumes CE_IN stays high and the host polls by mask write, read and write back.
*/
`timescale 1ns/100ps
module t1_alarm_checker
  import t1_alarm_pkg::*;
#(
  parameter int JA_DEPTH = JA_DEPTH_DEFAULT,
  parameter int JA_W = 8
) (
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic CE_IN,
  input wire logic RX_CLOCK_INPUT_IN,
  input wire logic SYNC_ACQUIRED_IN,
  input wire logic [1:0] LEVEL_CODE_IN,
  input wire logic [JA_W-1:0] JA_FILL_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic INT_N_OUT
);
  logic [11:0] idle_cnt_r;
  logic [11:0] idle_cnt_nxt;
  logic rx_clk_r;
  wire logic rd_cyc = CE_IN && RD_IN;
  wire logic rd_lvl = rd_cyc && (ADDR_IN == LEVEL_STATUS_ADDR);
  wire logic rd_alm = rd_cyc && (ADDR_IN == ALARM_STATUS_ADDR);
  wire logic arm_lvl = CE_IN && WR_IN && (ADDR_IN == LEVEL_STATUS_ADDR);
  wire logic mapped = (ADDR_IN == LEVEL_STATUS_ADDR) || (ADDR_IN == ALARM_STATUS_ADDR) ||
    (ADDR_IN == EVENT_FLAGS_ADDR);
  wire logic jit_cond = (int'(JA_FILL_IN) >= JA_DEPTH - JA_MARGIN) ||
    (int'(JA_FILL_IN) <= JA_MARGIN);

  // The count saturates so a long quiet spell never wraps back into the short range.
  assign idle_cnt_nxt = (RX_CLOCK_INPUT_IN != rx_clk_r) ? 12'h000 :
    idle_cnt_r + {11'h000, ~&idle_cnt_r};

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      idle_cnt_r <= 12'h000;
      rx_clk_r <= 1'b0;
    end else begin
      idle_cnt_r <= idle_cnt_nxt;
      rx_clk_r <= RX_CLOCK_INPUT_IN;
    end
  end

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);

  a_rdata_hold_idle: assert property (!rd_cyc |=> $stable(RDATA_OUT))
    else $error("Read data changed without a read.");
  a_unmapped_reads_zero: assert property (rd_cyc && !mapped |=> RDATA_OUT == UNMAPPED_READ)
    else $error("Unmapped read returned nonzero data.");
  a_spare_bits_zero: assert property (rd_lvl |=> RDATA_OUT[2:0] == 3'h0)
    else $error("Unassigned level bits read nonzero.");
  a_alarm_nibble_zero: assert property (rd_alm |=> RDATA_OUT[7:4] == 4'h0)
    else $error("Upper alarm bits read nonzero.");
  a_sync_change_int: assert property (
    CE_IN && $changed(SYNC_ACQUIRED_IN) |-> ##[1:2] !INT_N_OUT)
    else $error("Sync change did not pull the interrupt low.");
  a_int_holds_low: assert property (!INT_N_OUT && !rd_alm |=> !INT_N_OUT)
    else $error("Interrupt released without an alarm read.");
  a_level_code_read: assert property (
    arm_lvl && WDATA_IN[7:6] == 2'h3 && $stable(LEVEL_CODE_IN) ##1 rd_lvl
    |=> RDATA_OUT[7:6] == $past(LEVEL_CODE_IN, 2))
    else $error("Level code read back wrong.");
  a_jitter_flag_read: assert property (
    arm_lvl && WDATA_IN[5] && $past(jit_cond) && $past(jit_cond, 2) ##1 rd_lvl |=> RDATA_OUT[5])
    else $error("Jitter limit flag missing.");
  a_clock_loss_read: assert property (
    arm_lvl && WDATA_IN[4] && idle_cnt_r >= 12'h2f8 ##1 rd_lvl |=> RDATA_OUT[4])
    else $error("Receive clock loss flag missing.");

  c_event_read: cover property (rd_cyc && ADDR_IN == EVENT_FLAGS_ADDR ##1 RDATA_OUT != 8'h00);
  c_int_fall: cover property ($fell(INT_N_OUT));
  c_clock_loss: cover property (arm_lvl ##1 rd_lvl ##1 RDATA_OUT[4]);
endmodule

bind t1_receive_alarm_status t1_alarm_checker #(.JA_DEPTH(JA_DEPTH), .JA_W(JA_W))
  i_t1_alarm_checker (
  .REF_CLK_IN(REF_CLK_IN), .RSTN_IN(RSTN_IN), .CE_IN(CE_IN),
  .RX_CLOCK_INPUT_IN(RX_CLOCK_INPUT_IN), .SYNC_ACQUIRED_IN(SYNC_ACQUIRED_IN),
  .LEVEL_CODE_IN(LEVEL_CODE_IN), .JA_FILL_IN(JA_FILL_IN), .ADDR_IN(ADDR_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .WDATA_IN(WDATA_IN), .RDATA_OUT(RDATA_OUT),
  .INT_N_OUT(INT_N_OUT)
);

//--- verif/host_bus_model.sv
/*
  Host processor model that polls the status registers over the byte-wide port.
  Assumes the port takes a strobe at the rising edge and answers a read one cycle later.
*/
`timescale 1ns/100ps
module host_bus_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out
);
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end

  // Mask write, read, then write back the read value under the mask to clear those bits.
  task automatic poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    wdata_out = m;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    rd_out = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    d = rdata_in;
    wdata_out = rdata_in & m;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~wdata_out;
  endtask
endmodule

//--- verif/test_t1_receive_alarm_status.sv
/*
  Self-checking testbench for the T1 receive alarm block with a polling host model.
  Assumes the checker is bound in and the blue window is shortened to 200 cycles.
*/
`timescale 1ns/100ps
module test_t1_receive_alarm_status import t1_alarm_pkg::*;;
  logic clk, rstn, ce, rx_clk, rx_pos, rx_neg, sync, tx_full, tx_empty, tx_stb, tx_mark;
  logic ysel, esf, yval, wr, rd, int_n, pol;
  logic [1:0] level;
  logic [2:0] ystb;
  logic [7:0] ja_fill, addr, wdata, rdata, rv;
  logic [7:0] jcorner [4] = '{8'h7c, 8'h04, 8'h7b, 8'h05};
  int num_errors, check_count, seed;

  t1_receive_alarm_status #(.BLUE_CYC(200)) i_t1_receive_alarm_status (
    .REF_CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .RX_CLOCK_INPUT_IN(rx_clk),
    .RX_POSITIVE_RAIL_IN(rx_pos), .RX_NEGATIVE_RAIL_IN(rx_neg), .SYNC_ACQUIRED_IN(sync),
    .TX_STORE_FULL_IN(tx_full), .TX_STORE_EMPTY_IN(tx_empty), .TX_BIT_STB_IN(tx_stb),
    .TX_MARK_IN(tx_mark), .LEVEL_CODE_IN(level), .JA_FILL_IN(ja_fill),
    .YELLOW_MODE_SELECT_IN(ysel), .ESF_MODE_IN(esf), .CHAN_BIT2_STB_IN(ystb[0]),
    .CHAN_BIT2_IN(yval), .FBIT12_STB_IN(ystb[1]), .FBIT12_IN(yval),
    .FDL_PATTERN_STB_IN(ystb[2]), .FDL_PATTERN_MATCH_IN(yval), .ADDR_IN(addr),
    .WR_IN(wr), .RD_IN(rd), .WDATA_IN(wdata), .RDATA_OUT(rdata), .INT_N_OUT(int_n)
  );
  host_bus_model i_host_bus_model (
    .clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .rd_out(rd),
    .wdata_out(wdata)
  );

  function automatic logic [7:0] lvl_exp(input logic [1:0] code, input logic [7:0] f);
    return {code, (f >= 8'(JA_DEPTH_DEFAULT - JA_MARGIN)) || (f <= 8'(JA_MARGIN)), 5'h00};
  endfunction

  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task pollc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    i_host_bus_model.poll(a, m, rv);
    check(rv & m, exp);
  endtask

  // The first poll flushes latched history, so the second shows the present state.
  task settled(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    i_host_bus_model.poll(a, m, rv);
    pollc(a, m, exp);
  endtask

  task send_bit(input logic m);
    @(posedge clk);
    #1;
    rx_pos = m & pol;
    rx_neg = m & ~pol;
    rx_clk = 1'b1;
    pol = pol ^ m;
    repeat (2) @(posedge clk);
    #1;
    rx_clk = 1'b0;
    @(posedge clk);
  endtask

  task tx_bit(input logic m);
    @(posedge clk);
    #1;
    tx_stb = 1'b1;
    tx_mark = m;
    @(posedge clk);
    #1;
    tx_stb = 1'b0;
  endtask

  task ypulse(input int k, input logic v);
    @(posedge clk);
    #1;
    ystb = 3'h1 << k;
    yval = v;
    @(posedge clk);
    #1;
    ystb = 3'h0;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    {rstn, rx_clk, rx_pos, rx_neg, sync, tx_full, tx_empty, tx_stb, tx_mark} = 9'h000;
    {ysel, esf, yval, ystb, level} = 8'h00;
    ce = 1'b1;
    pol = 1'b1;
    ja_fill = 8'h40;
    seed = 5;
    num_errors = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (800) @(posedge clk);
    #1;
    check({7'h00, int_n}, 8'h00);
    pollc(ALARM_STATUS_ADDR, 8'h0f, 8'h0b);
    check({7'h00, int_n}, 8'h01);
    pollc(LEVEL_STATUS_ADDR, 8'h18, 8'h18);
    for (int i = 0; i < 8; i++) begin
      level = i[1:0];
      ja_fill = (i < 4) ? 8'(5 + ($unsigned($random(seed)) % 119)) : jcorner[i - 4];
      repeat (3) @(posedge clk);
      settled(LEVEL_STATUS_ADDR, 8'he7, lvl_exp(i[1:0], ja_fill));
    end
    repeat (13) send_bit(1'b1);
    settled(ALARM_STATUS_ADDR, 8'h02, 8'h02);
    send_bit(1'b1);
    pollc(ALARM_STATUS_ADDR, 8'h02, 8'h02);
    pollc(ALARM_STATUS_ADDR, 8'h02, 8'h00);
    pollc(EVENT_FLAGS_ADDR, 8'h40, 8'h40);
    settled(LEVEL_STATUS_ADDR, 8'h08, 8'h00);
    for (int i = 0; i < 80; i++) send_bit(i[1:0] != 2'h0 && (i[0] || 1'($random(seed))));
    settled(ALARM_STATUS_ADDR, 8'h08, 8'h00);
    pollc(EVENT_FLAGS_ADDR, 8'h04, 8'h04);
    // A leading one breaks any zero run left over from the previous traffic.
    send_bit(1'b1);
    repeat (15) send_bit(1'b0);
    pollc(EVENT_FLAGS_ADDR, 8'h02, 8'h00);
    send_bit(1'b0);
    pollc(EVENT_FLAGS_ADDR, 8'h02, 8'h02);
    pollc(EVENT_FLAGS_ADDR, 8'h02, 8'h00);
    tx_bit(1'b1);
    tx_full = 1'b1;
    sync = 1'b1;
    repeat (15) tx_bit(1'b0);
    tx_full = 1'b0;
    pollc(EVENT_FLAGS_ADDR, 8'h01, 8'h00);
    tx_bit(1'b0);
    pollc(EVENT_FLAGS_ADDR, 8'hff, 8'ha9);
    tx_bit(1'b1);
    tx_empty = 1'b1;
    @(posedge clk);
    #1;
    tx_empty = 1'b0;
    pollc(EVENT_FLAGS_ADDR, 8'h39, 8'h18);
    // With the clock enable low the latches are frozen, so this full pulse must be lost.
    ce = 1'b0;
    tx_full = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    tx_full = 1'b0;
    ce = 1'b1;
    pollc(EVENT_FLAGS_ADDR, 8'h20, 8'h00);
    pollc(8'h00, 8'hff, UNMAPPED_READ);
    send_bit(1'b1);
    repeat (191) send_bit(1'b0);
    settled(ALARM_STATUS_ADDR, 8'h02, 8'h00);
    send_bit(1'b0);
    settled(ALARM_STATUS_ADDR, 8'h03, 8'h02);
    settled(LEVEL_STATUS_ADDR, 8'h08, 8'h08);
    for (int i = 0; i < 256; i++) ypulse(0, i < 2);
    settled(ALARM_STATUS_ADDR, 8'h04, 8'h04);
    for (int i = 0; i < 256; i++) ypulse(0, i < 3);
    settled(ALARM_STATUS_ADDR, 8'h04, 8'h00);
    ysel = 1'b1;
    repeat (2) ypulse(1, 1'b1);
    settled(ALARM_STATUS_ADDR, 8'h04, 8'h04);
    ypulse(1, 1'b0);
    settled(ALARM_STATUS_ADDR, 8'h04, 8'h04);
    ypulse(1, 1'b0);
    settled(ALARM_STATUS_ADDR, 8'h04, 8'h00);
    esf = 1'b1;
    repeat (15) ypulse(2, 1'b1);
    settled(ALARM_STATUS_ADDR, 8'h04, 8'h00);
    ypulse(2, 1'b1);
    settled(ALARM_STATUS_ADDR, 8'h04, 8'h04);
    repeat (2) ypulse(2, 1'b0);
    repeat (14) ypulse(2, 1'b1);
    settled(ALARM_STATUS_ADDR, 8'h04, 8'h00);
    print_verdict();
  end
endmodule
